// >>> mcs_card_ctrl.sv
// Card command interpreter and state control of an embedded MMC device.
// Assumes MMC clock, command and hardware reset pins asynchronous to clk,
// and an MMC clock well below clk/4 so every bus edge is seen.
//
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/10ps
module mcs_card_ctrl
  import mcs_pkg::*;
#(
  parameter int AUTO_SLEEP_CYCLES = AUTO_SLEEP_CYC,
  parameter logic [31:0] SA_CYCLES = 32'h40,
  parameter logic [31:0] PROG_CYCLES = 32'h20,
  parameter logic [31:0] ERASE_CYCLES = 32'h40,
  parameter logic [31:0] OVW_CYCLES = 32'h20,
  parameter logic [31:0] BKOPS_CYCLES = 32'h80,
  parameter logic [31:0] OCR = 32'h80FF_8000,
  // Identification word value is arbitrary
  parameter logic [31:0] CID_WORD = 32'h1234_5678
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic mmc_clk,
  input wire logic mmc_cmd_i,
  output logic mmc_cmd_o,
  output logic mmc_cmd_oe,
  input wire logic mmc_dat0_i,
  output logic mmc_dat0_o,
  output logic mmc_dat0_oe,
  input wire logic hw_rst_n,
  output logic power_save,
  output logic [7:0] bus_width,
  output logic [7:0] high_speed_timing_select,
  output logic [3:0] mem_op,
  output logic mem_overwrite,
  output logic mem_block_unit,
  output logic mem_commit,
  output logic mem_abort
);
  logic [2:0] pins_s;
  logic clk_prev_q, hw_prev_q;
  mcs_link_t link_q;
  mcs_state_t state_q, nst, end_st;
  mcs_op_t op_q, nop;
  logic [5:0] cnt_q;
  logic [47:0] rx_q, tx_q;
  logic done_q, raw_q, out_q, drive_q;
  logic [15:0] rca_q;
  logic [31:0] op_cnt_q, ers_addr_q, op_load, status_w;
  logic purge_q, commit_q, abort_q;
  logic ill_q, wpv_q, crc_err_q;
  logic [7:0] bus_width_q, hs_q;
  logic [31:0] idle_cnt_q;
  logic psave_q;
  logic perm_wp_q, tmp_wp_q;
  logic [7:0] seg_perm_q, seg_pwr_q, seg_tmp_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic rsp, raw, ill, wpv;
  logic [3:0] st_code;

  mcs_sync #(.WIDTH(3), .RST_VAL(3'h7)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({hw_rst_n, mmc_cmd_i, mmc_clk}),
    .sync_q(pins_s)
  );
  mcs_crc_if crc_b();
  mcs_crc7 u_crc (
    .clk(clk),
    .rst_n(rst_n),
    .bus(crc_b.gen)
  );

  wire clk_s = pins_s[0];
  wire cmd_s = pins_s[1];
  wire hw_s = pins_s[2];
  wire rise = clk_s && !clk_prev_q;
  wire fall = !clk_s && clk_prev_q;
  wire hw_rise = hw_s && !hw_prev_q;
  wire start_bit = rise && link_q == L_IDLE && !cmd_s;

  // Frame fields, valid in the cycle after the last bit
  wire [5:0] idx = rx_q[45:40];
  wire [31:0] arg = rx_q[39:8];
  wire crc_ok = rx_q[46] && rx_q[0] && rx_q[7:1] == crc_b.crc;
  wire own = arg[31:16] == rca_q;
  wire rca_set = rca_q != 16'h0;
  wire busy = op_q != OP_NONE;
  wire is_reset = idx == CMD_GO_IDLE && (arg == ARG_RESET || arg == ARG_RESET_ALT);
  wire op_irq = op_q inside {OP_PROG, OP_ERASE, OP_TRIM, OP_SERASE, OP_STRIM, OP_BKOPS};
  wire hpi_cmd12 = HPI_FEATURES[HPI_IMPL_BIT];
  wire hpi_hit = arg[HPI_BIT] && op_irq
    && ((idx == CMD_STOP && hpi_cmd12) || (idx == CMD_STATUS && own && !hpi_cmd12));
  wire sleep_ok = state_q != S_SLP || idx == CMD_GO_IDLE || idx == CMD_SLEEP;
  // Any running operation blocks new commands until done; reset, stop, status and select still pass
  wire busy_ok = !busy || idx inside {CMD_GO_IDLE, CMD_STOP, CMD_STATUS, CMD_SELECT};
  wire take = done_q && crc_ok && sleep_ok && busy_ok;
  wire soft_rst = hw_rise || (take && is_reset);
  wire sw_wr = take && idx == CMD_SWITCH && state_q == S_TRAN && arg[25:24] == SW_WRITE_BYTE;
  wire hpi_abort = take && hpi_hit;
  wire op_last = busy && op_cnt_q == 32'h0;
  wire op_end = op_last && !purge_q;

  function automatic logic wp_hit(input logic [31:0] addr, input logic [7:0] sp,
                                  input logic [7:0] sw, input logic [7:0] st,
                                  input logic perm, input logic tmp);
    logic [SEG_BITS-1:0] seg;
    seg = addr[SEG_LSB +: SEG_BITS];
    wp_hit = perm || tmp || sp[seg] || sw[seg] || st[seg];
  endfunction

  wire wp_wr = wp_hit(arg, seg_perm_q, seg_pwr_q, seg_tmp_q, perm_wp_q, tmp_wp_q);
  wire wp_er = wp_hit(ers_addr_q, seg_perm_q, seg_pwr_q, seg_tmp_q, perm_wp_q, tmp_wp_q);

  always_comb begin
    nst = state_q;
    nop = OP_NONE;
    rsp = 1'b0;
    raw = 1'b0;
    ill = 1'b0;
    wpv = 1'b0;
    case (idx)
      CMD_GO_IDLE: begin
        if (is_reset) nst = S_IDLE;
      end
      CMD_SEND_OP: begin
        if (state_q == S_IDLE && !rca_set) begin
          nst = S_READY;
          rsp = 1'b1;
          raw = 1'b1;
        end
      end
      CMD_ALL_CID: begin
        if (state_q == S_READY && !rca_set) begin
          nst = S_IDENT;
          rsp = 1'b1;
        end
      end
      CMD_SET_RCA: begin
        if (state_q == S_IDENT && !rca_set && arg[31:16] != 16'h0) begin
          nst = S_STBY;
          rsp = 1'b1;
        end
      end
      CMD_SLEEP: begin
        if (own && state_q == S_STBY && arg[SLEEP_BIT]) begin
          nop = OP_SLEEP;
          rsp = 1'b1;
        end else if (own && state_q == S_SLP && !arg[SLEEP_BIT]) begin
          nop = OP_WAKE;
          rsp = 1'b1;
        end
      end
      CMD_SELECT: begin
        case (state_q)
          S_STBY: if (own) begin
            nst = S_TRAN;
            rsp = 1'b1;
          end
          S_TRAN: if (own) ill = 1'b1; else nst = S_STBY;
          S_DIS: if (own) begin
            nst = S_PRG;
            rsp = 1'b1;
          end
          S_PRG: if (own) ill = 1'b1; else nst = S_DIS;
          default: ill = 1'b0;
        endcase
      end
      CMD_SWITCH: begin
        if (state_q == S_TRAN) begin
          rsp = 1'b1;
          if (sw_wr && arg[23:16] == EXT_BG_START) begin
            nop = OP_BKOPS;
            nst = S_PRG;
          end
        end
      end
      CMD_STOP: begin
        if (state_q == S_TRAN || state_q == S_PRG) rsp = 1'b1;
      end
      CMD_STATUS: begin
        if (own && rca_set && state_q != S_SLP) rsp = 1'b1;
      end
      CMD_WRITE_BLK, CMD_WRITE_MULT: begin
        if (state_q == S_TRAN) begin
          rsp = 1'b1;
          if (wp_wr) begin
            wpv = 1'b1;
          end else begin
            nop = OP_PROG;
            nst = S_PRG;
          end
        end
      end
      CMD_ERASE_START: begin
        if (state_q == S_TRAN) rsp = 1'b1;
      end
      CMD_ERASE: begin
        if (state_q == S_TRAN) begin
          rsp = 1'b1;
          nst = S_PRG;
          if (wp_er) begin
            wpv = 1'b1;
            nst = S_TRAN;
          end else if (arg == ARG_TRIM) nop = OP_TRIM;
          else if (arg == ARG_SEC_ERASE) nop = OP_SERASE;
          else if (arg == ARG_SEC_TRIM) nop = OP_STRIM;
          else nop = OP_ERASE;
        end
      end
      default: begin
        ill = state_q == S_TRAN;
        rsp = state_q == S_TRAN;
      end
    endcase
    if (hpi_hit) nst = (state_q == S_DIS) ? S_STBY : S_TRAN;
  end

  always_comb begin
    case (op_q)
      OP_SLEEP: end_st = S_SLP;
      OP_WAKE: end_st = S_STBY;
      default: end_st = (state_q == S_DIS) ? S_STBY : S_TRAN;
    endcase
  end

  always_comb begin
    case (nop)
      OP_PROG: op_load = PROG_CYCLES;
      OP_SERASE, OP_STRIM: op_load = OVW_CYCLES;
      OP_BKOPS: op_load = BKOPS_CYCLES;
      OP_SLEEP, OP_WAKE: op_load = SA_CYCLES;
      default: op_load = ERASE_CYCLES;
    endcase
  end

  always_comb begin
    case (state_q)
      S_READY: st_code = CS_READY;
      S_IDENT: st_code = CS_IDENT;
      S_STBY: st_code = CS_STBY;
      S_TRAN: st_code = CS_TRAN;
      S_PRG: st_code = CS_PRG;
      S_DIS: st_code = CS_DIS;
      S_SLP: st_code = CS_SLP;
      default: st_code = CS_IDLE;
    endcase
    status_w = 32'h0;
    status_w[ST_WP_VIOL] = wpv_q;
    status_w[ST_CRC_ERR] = crc_err_q;
    status_w[ST_ILLEGAL] = ill_q;
    status_w[ST_STATE_LSB +: 4] = st_code;
    status_w[ST_READY] = !busy;
  end

  wire [31:0] rsp_arg = raw ? OCR : (idx == CMD_ALL_CID) ? CID_WORD : status_w;
  wire [5:0] rsp_idx = raw ? R3_INDEX : idx;
  wire load_rsp = take && rsp;
  wire [2:0] crc_sel = 3'(CRC_LAST - cnt_q);
  wire tx_bit = (cnt_q < CRC_START) ? tx_q[47]
    : (cnt_q <= CRC_LAST && !raw_q) ? crc_b.crc[crc_sel] : 1'b1;

  assign crc_b.clr = link_q == L_IDLE || link_q == L_WAIT;
  assign crc_b.en = (link_q == L_RX && rise && cnt_q < CRC_START)
    || (link_q == L_TX && fall && cnt_q < CRC_START);
  assign crc_b.din = (link_q == L_TX) ? tx_q[47] : cmd_s;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_prev_q <= 1'b1;
      hw_prev_q <= 1'b1;
    end else begin
      clk_prev_q <= clk_s;
      hw_prev_q <= hw_s;
    end
  end

  // Receive, turnaround and response shifter
  always_ff @(posedge clk) begin
    if (!rst_n || hw_rise) begin
      link_q <= L_IDLE;
      cnt_q <= 6'h00;
      rx_q <= '0;
      tx_q <= '0;
      done_q <= 1'b0;
      raw_q <= 1'b0;
      out_q <= 1'b1;
      drive_q <= 1'b0;
    end else begin
      done_q <= link_q == L_RX && rise && cnt_q == FRAME_LAST;
      case (link_q)
        L_IDLE: begin
          if (load_rsp) begin
            link_q <= L_WAIT;
            tx_q <= {2'h0, rsp_idx, rsp_arg, 8'h01};
            raw_q <= raw;
            cnt_q <= 6'h00;
          end else if (start_bit) begin
            link_q <= L_RX;
            rx_q <= {rx_q[46:0], cmd_s};
            cnt_q <= 6'h01;
          end
        end
        L_RX: if (rise) begin
          rx_q <= {rx_q[46:0], cmd_s};
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == FRAME_LAST) link_q <= L_IDLE;
        end
        L_WAIT: if (rise) begin
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == NCR_CLKS - 6'h01) begin
            link_q <= L_TX;
            cnt_q <= 6'h00;
          end
        end
        L_TX: if (fall) begin
          cnt_q <= cnt_q + 6'h01;
          out_q <= tx_bit;
          tx_q <= {tx_q[46:0], 1'b1};
          drive_q <= cnt_q != FRAME_END;
          if (cnt_q == FRAME_END) begin
            link_q <= L_IDLE;
            out_q <= 1'b1;
          end
        end
        default: link_q <= L_IDLE;
      endcase
    end
  end

  wire id_mode = state_q inside {S_IDLE, S_READY, S_IDENT};
  assign mmc_cmd_o = out_q;
  // Open drain in identification: devices share the line
  assign mmc_cmd_oe = drive_q && (!id_mode || !out_q);
  // Busy uses only the lowest data line
  assign mmc_dat0_o = 1'b0;
  assign mmc_dat0_oe = busy && !id_mode;

  always_ff @(posedge clk) begin
    if (!rst_n || soft_rst) begin
      state_q <= S_IDLE;
      rca_q <= 16'h0;
    end else if (take) begin
      state_q <= nst;
      if (idx == CMD_SET_RCA && nst == S_STBY) rca_q <= arg[31:16];
    end else if (op_end) begin
      state_q <= end_st;
    end
  end

  // Purge: overwrite first, then erase
  always_ff @(posedge clk) begin
    if (!rst_n || soft_rst) begin
      op_q <= OP_NONE;
      op_cnt_q <= 32'h0;
      purge_q <= 1'b0;
      ers_addr_q <= 32'h0;
    end else if (hpi_abort) begin
      op_q <= OP_NONE;
      purge_q <= 1'b0;
    end else if (take && nop != OP_NONE) begin
      op_q <= nop;
      op_cnt_q <= op_load;
      purge_q <= nop == OP_SERASE || nop == OP_STRIM;
    end else if (op_last && purge_q) begin
      purge_q <= 1'b0;
      op_cnt_q <= ERASE_CYCLES;
    end else if (op_end) begin
      op_q <= OP_NONE;
    end else if (busy) begin
      op_cnt_q <= op_cnt_q - 32'h1;
    end
    if (rst_n && !soft_rst && take && idx == CMD_ERASE_START) ers_addr_q <= arg;
  end

  // Data turns current only at full completion
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      commit_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      commit_q <= op_end && op_q == OP_PROG;
      abort_q <= hpi_abort || (hw_rise && busy);
    end
  end

  assign mem_op = op_q;
  assign mem_overwrite = purge_q;
  assign mem_block_unit = op_q == OP_TRIM || op_q == OP_STRIM;
  assign mem_commit = commit_q;
  assign mem_abort = abort_q;

  // A new flag event wins over the clear by a response
  always_ff @(posedge clk) begin
    if (!rst_n || soft_rst) begin
      ill_q <= 1'b0;
      wpv_q <= 1'b0;
      crc_err_q <= 1'b0;
    end else begin
      ill_q <= (ill_q && !load_rsp) || (take && ill);
      wpv_q <= (wpv_q && !load_rsp) || (take && wpv);
      crc_err_q <= (crc_err_q && !load_rsp) || (done_q && !crc_ok);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || soft_rst) begin
      bus_width_q <= BUS_WIDTH_RST;
      hs_q <= HS_SEL_RST;
    end else if (sw_wr && arg[23:16] == EXT_BUS_WIDTH) begin
      bus_width_q <= arg[15:8];
    end else if (sw_wr && arg[23:16] == EXT_HS_SEL) begin
      hs_q <= arg[15:8];
    end
  end
  assign bus_width = bus_width_q;
  assign high_speed_timing_select = hs_q;

  always_ff @(posedge clk) begin
    if (!rst_n || start_bit || busy || link_q != L_IDLE) begin
      idle_cnt_q <= 32'h0;
      psave_q <= 1'b0;
    end else if (idle_cnt_q == 32'(AUTO_SLEEP_CYCLES - 1)) begin
      psave_q <= 1'b1;
    end else begin
      idle_cnt_q <= idle_cnt_q + 32'h1;
    end
  end
  assign power_save = psave_q;

  // One wait state; data taken where waitrequest is low
  wire req = avs_read || avs_write;
  wire wr_en = avs_write && ack_q && avs_address == REG_WP;
  assign avs_waitrequest = req && !ack_q;
  wire [31:0] rd_mux = (avs_address == REG_STATUS)
      ? {HPI_FEATURES, bus_width_q, 4'h0, hs_q[0], purge_q, psave_q, busy, op_q, st_code}
    : (avs_address == REG_RCA) ? {16'h0, rca_q}
    : (avs_address == REG_WP) ? {seg_tmp_q, seg_pwr_q, seg_perm_q, 6'h00, tmp_wp_q, perm_wp_q}
    : (avs_address == REG_FLAGS) ? {26'h0, rx_q[45:43], crc_err_q, wpv_q, ill_q}
    : 32'h0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= req && !ack_q;
      if (avs_read && !ack_q) rdata_q <= rd_mux;
    end
  end
  assign avs_readdata = rdata_q;

  // Permanent bits set-only; power-on bits clear on hardware reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      perm_wp_q <= 1'b0;
      tmp_wp_q <= 1'b0;
      seg_perm_q <= 8'h00;
      seg_pwr_q <= 8'h00;
      seg_tmp_q <= 8'h00;
    end else if (hw_rise) begin
      seg_pwr_q <= 8'h00;
    end else if (wr_en) begin
      perm_wp_q <= perm_wp_q || avs_writedata[0];
      tmp_wp_q <= avs_writedata[1];
      seg_perm_q <= seg_perm_q | avs_writedata[15:8];
      seg_pwr_q <= seg_pwr_q | avs_writedata[23:16];
      seg_tmp_q <= avs_writedata[31:24];
    end
  end
endmodule

// >>> mcs_pkg.sv
// Constants, codes and types of the MMC card state controller.
// Assumes a 10 MHz system clock; the MMC bus clock is sampled as data.
// Overview of operation
// - Identification uses only the command line
// - 1ms idle after completion: power saving
// - Power saving serves commands normally
// - Sleep command bit 15 selects sleep or wake
// - Asleep, only reset and sleep commands act
// - Sleep transitions end within timeout
// - Reset pin rising edge resets device
// - Reliable write keeps old data until programmed
// - Secure erase runs now; everyone waits
// - Secure erase overwrites then erases erase groups
// - Secure trim purges single 512B blocks
// - Trim erases 512B blocks without overwrite
// - Device and segment protection block writes
// - Priority interrupt aborts long operations
// - Priority interrupt via stop or status command
// - Only writes, erase, background start are interruptible
// - Addressed transfer-mode commands get responses
// - Select command toggles standby and transfer
// - Assigned address silences identification commands
// - Select command toggles disconnect and programming
// - Background start: busy until done
// - Bus width byte resets to zero
// - Only lowest data line used after reset
package mcs_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int AUTO_SLEEP_MS = 1;
  localparam int AUTO_SLEEP_CYC = AUTO_SLEEP_MS * (CLK_HZ / 1000);
  localparam logic [5:0] NCR_CLKS = 6'h02;
  localparam logic [5:0] FRAME_LAST = 6'h2F;
  localparam logic [5:0] CRC_START = 6'h28;
  localparam logic [5:0] CRC_LAST = 6'h2E;
  localparam logic [5:0] FRAME_END = 6'h30;

  localparam logic [5:0] CMD_GO_IDLE = 6'h00;
  localparam logic [5:0] CMD_SEND_OP = 6'h01;
  localparam logic [5:0] CMD_ALL_CID = 6'h02;
  localparam logic [5:0] CMD_SET_RCA = 6'h03;
  localparam logic [5:0] CMD_SLEEP = 6'h05;
  localparam logic [5:0] CMD_SWITCH = 6'h06;
  localparam logic [5:0] CMD_SELECT = 6'h07;
  localparam logic [5:0] CMD_STOP = 6'h0C;
  localparam logic [5:0] CMD_STATUS = 6'h0D;
  localparam logic [5:0] CMD_WRITE_BLK = 6'h18;
  localparam logic [5:0] CMD_WRITE_MULT = 6'h19;
  localparam logic [5:0] CMD_ERASE_START = 6'h23;
  localparam logic [5:0] CMD_ERASE = 6'h26;
  localparam logic [5:0] R3_INDEX = 6'h3F;

  localparam logic [31:0] ARG_RESET = 32'h0000_0000;
  localparam logic [31:0] ARG_RESET_ALT = 32'hF0F0_F0F0;
  localparam logic [31:0] ARG_TRIM = 32'h0000_0001;
  localparam logic [31:0] ARG_SEC_ERASE = 32'h8000_0000;
  localparam logic [31:0] ARG_SEC_TRIM = 32'h8000_0001;
  localparam int SLEEP_BIT = 15;
  localparam int HPI_BIT = 0;
  localparam logic [1:0] SW_WRITE_BYTE = 2'h3;
  localparam logic [7:0] EXT_BG_START = 8'hA4;
  localparam logic [7:0] EXT_BUS_WIDTH = 8'hB7;
  localparam logic [7:0] EXT_HS_SEL = 8'hB9;
  localparam logic [7:0] HPI_FEATURES = 8'h03;
  localparam int HPI_IMPL_BIT = 1;
  localparam logic [7:0] BUS_WIDTH_RST = 8'h00;
  localparam logic [7:0] HS_SEL_RST = 8'h00;
  localparam int SEG_BITS = 3;
  localparam int SEG_LSB = 22;

  localparam int ST_WP_VIOL = 26;
  localparam int ST_CRC_ERR = 23;
  localparam int ST_ILLEGAL = 22;
  localparam int ST_STATE_LSB = 9;
  localparam int ST_READY = 8;
  localparam logic [3:0] CS_IDLE = 4'h0;
  localparam logic [3:0] CS_READY = 4'h1;
  localparam logic [3:0] CS_IDENT = 4'h2;
  localparam logic [3:0] CS_STBY = 4'h3;
  localparam logic [3:0] CS_TRAN = 4'h4;
  localparam logic [3:0] CS_PRG = 4'h7;
  localparam logic [3:0] CS_DIS = 4'h8;
  localparam logic [3:0] CS_SLP = 4'hA;

  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_RCA = 4'h4;
  localparam logic [3:0] REG_WP = 4'h8;
  localparam logic [3:0] REG_FLAGS = 4'hC;

  typedef enum logic [3:0] {
    S_IDLE, S_READY, S_IDENT, S_STBY, S_TRAN, S_PRG, S_DIS, S_SLP
  } mcs_state_t;
  typedef enum logic [3:0] {
    OP_NONE, OP_PROG, OP_ERASE, OP_TRIM, OP_SERASE, OP_STRIM, OP_BKOPS, OP_SLEEP, OP_WAKE
  } mcs_op_t;
  typedef enum logic [1:0] {L_IDLE, L_RX, L_WAIT, L_TX} mcs_link_t;
endpackage

// >>> mcs_crc_if.sv
// Serial CRC7 request and result bundle.
// Driven by the card controller, served by the CRC engine.
`timescale 1ns/10ps
interface mcs_crc_if;
  logic clr;
  logic en;
  logic din;
  logic [6:0] crc;
  modport gen (input clr, input en, input din, output crc);
  modport user (output clr, output en, input crc, output din);
endinterface

// >>> mcs_sync.sv
// Two-flop synchroniser and CRC7 engine of the card controller.
// Inputs to the synchroniser are asynchronous to clk.
`timescale 1ns/10ps
module mcs_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] sync_q
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end
endmodule

module mcs_crc7 (
  input wire logic clk,
  input wire logic rst_n,
  mcs_crc_if.gen bus
);
  logic [6:0] crc_q;
  wire fb = bus.din ^ crc_q[6];
  // Polynomial x^7 + x^3 + 1
  always_ff @(posedge clk) begin
    if (!rst_n || bus.clr) begin
      crc_q <= 7'h00;
    end else if (bus.en) begin
      crc_q <= {crc_q[5:0], 1'b0} ^ {3'h0, fb, 2'h0, fb};
    end
  end
  assign bus.crc = crc_q;
endmodule

// >>> mcs_card_ctrl_chk.sv
// Port-level checker for the card controller, bound to its top module.
// Assumes one clk domain with synchronous active-low rst_n.
`timescale 1ns/10ps
module mcs_card_ctrl_chk
  import mcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mmc_cmd_oe,
  input wire logic mmc_dat0_o,
  input wire logic mmc_dat0_oe,
  input wire logic power_save,
  input wire logic [7:0] bus_width,
  input wire logic [7:0] high_speed_timing_select,
  input wire logic [3:0] mem_op,
  input wire logic mem_overwrite,
  input wire logic mem_block_unit,
  input wire logic mem_commit,
  input wire logic mem_abort
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rst_bytes;
    $rose(rst_n) |-> bus_width == 8'h00 && high_speed_timing_select == 8'h00;
  endproperty
  a_rst_bytes: assert property (p_rst_bytes) else $error("mode bytes set");
  property p_trim;
    mem_op == OP_TRIM |-> mem_block_unit && !mem_overwrite;
  endproperty
  a_trim: assert property (p_trim) else $error("bad trim");
  property p_strim;
    mem_op == OP_STRIM |-> mem_block_unit;
  endproperty
  a_strim: assert property (p_strim) else $error("secure trim not on blocks");
  property p_serase;
    mem_op == OP_SERASE |-> !mem_block_unit;
  endproperty
  a_serase: assert property (p_serase) else $error("secure erase on blocks");
  // Overwrite leads into the erase phase
  property p_purge;
    $fell(mem_overwrite) |-> mem_op inside {OP_SERASE, OP_STRIM};
  endproperty
  a_purge: assert property (p_purge) else $error("purge without erase");
  property p_busy;
    mem_overwrite |-> mmc_dat0_oe && !mmc_dat0_o;
  endproperty
  a_busy: assert property (p_busy) else $error("no busy during purge");
  property p_abort;
    mem_abort |-> ##[1:3] mem_op == OP_NONE;
  endproperty
  a_abort: assert property (p_abort) else $error("abort left op running");
  property p_commit;
    mem_commit |-> !mem_abort && ($past(mem_op) == OP_PROG || mem_op == OP_PROG);
  endproperty
  a_commit: assert property (p_commit) else $error("commit outside program");
  property p_psave;
    $rose(power_save) |-> !mmc_dat0_oe && !mmc_cmd_oe;
  endproperty
  a_psave: assert property (p_psave) else $error("saving while active");
  c_abort: cover property (mem_abort);
  c_psave: cover property ($rose(power_save));
  c_purge: cover property ($fell(mem_overwrite));
endmodule
bind mcs_card_ctrl mcs_card_ctrl_chk u_chk (.*);

// >>> mcs_host_model.sv
// Behavioural MMC host: sends 48-bit command frames and captures replies.
// Assumes a pull-up on the command wire in the bench.
`timescale 1ns/10ps
module mcs_host_model (
  output logic mmc_clk,
  output logic cmd_o,
  output logic cmd_oe,
  input wire logic cmd_line
);
  logic [47:0] resp;
  logic got;
  initial begin
    mmc_clk = 0;
    cmd_o = 1;
    cmd_oe = 0;
  end
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    end
    return c;
  endfunction
  // Clock runs only inside a frame, its reply window and 8 trailing cycles
  task automatic tick(output logic b);
    #400 mmc_clk = 1;
    b = cmd_line;
    #400 mmc_clk = 0;
  endtask
  task automatic send(input logic [5:0] idx, input logic [31:0] arg);
    logic [47:0] f;
    logic b;
    f = {2'b01, idx, arg, crc7({2'b01, idx, arg}), 1'b1};
    got = 0;
    resp = '0;
    #37 cmd_oe = 1;
    for (int i = 47; i >= 0; i--) begin
      cmd_o = f[i];
      tick(b);
    end
    cmd_oe = 0;
    for (int i = 0; i < 64 && !got; i++) begin
      tick(b);
      got = !b;
    end
    for (int i = 0; i < 47 && got; i++) begin
      tick(b);
      resp = {resp[46:0], b};
    end
    repeat (8) tick(b);
  endtask
endmodule

// >>> mcs_card_ctrl_tb.sv
// Self-checking bench of the card controller with a behavioural host.
// Assumes a shortened auto-sleep timer and lengthened operation timers so stop commands land mid-operation.
`timescale 1ns/10ps
module mcs_card_ctrl_tb
  import mcs_pkg::*;
;
  logic clk, rst_n, avs_read, avs_write, mmc_clk, hw_rst_n, h_o, h_oe, power_save, mmc_cmd_o;
  logic mmc_cmd_oe, mmc_dat0_o, mmc_dat0_oe, mem_overwrite, mem_block_unit, mem_commit, mem_abort;
  logic [3:0] avs_address, mem_op;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic avs_waitrequest;
  logic [7:0] bus_width, high_speed_timing_select;
  int failures, checks;
  localparam logic [31:0] RCA = 32'h0001_0000;
  wire logic mmc_cmd_i = h_oe ? h_o : (mmc_cmd_oe ? mmc_cmd_o : 1'b1);
  wire logic mmc_dat0_i = mmc_dat0_oe ? mmc_dat0_o : 1'b1;
  mcs_card_ctrl #(.AUTO_SLEEP_CYCLES(50), .ERASE_CYCLES(32'h2000),
    .OVW_CYCLES(32'h400), .BKOPS_CYCLES(32'h2000)) uut (.*);
  mcs_host_model h (.mmc_clk(mmc_clk), .cmd_o(h_o), .cmd_oe(h_oe), .cmd_line(mmc_cmd_i));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      failures++;
      end_sim();
    end
    q = avs_readdata;
    {avs_write, avs_read} <= 2'b00;
  endtask
  task automatic st(input logic [3:0] e);
    bus(0, REG_STATUS, 32'h0);
    chk("state", 32'(e), 32'(q[3:0]));
  endtask
  task automatic busy_wait(input int lim);
    int n;
    for (n = 0; n < lim && mmc_dat0_oe !== 1'b0; n++) @(posedge clk);
    chk("busy end", 32'h1, 32'(n < lim));
    if (n >= lim) end_sim();
  endtask
  task automatic t_reset;
    bus(1, REG_STATUS, 32'hFFFF_FFFF);
    st(CS_IDLE);
    chk("hpi features", 32'(HPI_FEATURES), 32'(q[31:24]));
    chk("width", 32'h0, 32'(bus_width));
    bus(0, 4'h6, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("reset test done");
  endtask
  task automatic t_ident;
    h.send(CMD_SEND_OP, 32'h40FF_8000);
    chk("r3 index", 32'(R3_INDEX), 32'(h.resp[45:40]));
    h.send(CMD_ALL_CID, 32'h0);
    h.send(CMD_SET_RCA, RCA);
    chk("rca reply", 32'h1, 32'(h.got));
    h.send(CMD_SEND_OP, 32'h40FF_8000);
    chk("ident silent", 32'h0, 32'(h.got));
    st(CS_STBY);
    $display("ident test done");
  endtask
  task automatic t_sel;
    h.send(CMD_SELECT, RCA);
    chk("r1 state", 32'(CS_STBY), 32'(h.resp[20:17]));
    st(CS_TRAN);
    h.send(CMD_SELECT, RCA);
    st(CS_TRAN);
    h.send(CMD_SWITCH, 32'h03B7_0200);
    chk("width", 32'h2, 32'(bus_width));
    h.send(CMD_SWITCH, 32'h03B9_0100);
    chk("hs", 32'h1, 32'(high_speed_timing_select));
    $display("select test done");
  endtask
  task automatic t_ops;
    h.send(CMD_WRITE_BLK, 32'h0);
    busy_wait(2000);
    h.send(CMD_ERASE, ARG_TRIM);
    chk("trim op", 32'(OP_TRIM), 32'(mem_op));
    chk("trim busy", 32'h1, 32'(mmc_dat0_oe));
    h.send(CMD_STOP, 32'h1);
    chk("abort", 32'(OP_NONE), 32'(mem_op));
    h.send(CMD_ERASE, ARG_SEC_TRIM);
    busy_wait(12000);
    h.send(CMD_SWITCH, 32'h03A4_0100);
    chk("bkops op", 32'(OP_BKOPS), 32'(mem_op));
    h.send(CMD_STOP, 32'h1);
    chk("bkops abort", 32'(OP_NONE), 32'(mem_op));
    $display("operation test done");
  endtask
  task automatic t_sleep;
    h.send(CMD_SELECT, 32'h0);
    st(CS_STBY);
    h.send(CMD_SLEEP, RCA | 32'h8000);
    busy_wait(2000);
    st(CS_SLP);
    h.send(CMD_STATUS, RCA);
    chk("asleep silent", 32'h0, 32'(h.got));
    h.send(CMD_SLEEP, RCA);
    busy_wait(2000);
    st(CS_STBY);
    $display("sleep test done");
  endtask
  task automatic t_psave_rst;
    for (int n = 0; n < 200 && power_save !== 1'b1; n++) @(posedge clk);
    chk("power save", 32'h1, 32'(power_save));
    if (power_save !== 1'b1) end_sim();
    h.send(CMD_STATUS, RCA);
    chk("served", 32'h1, 32'(h.got));
    @(posedge clk);
    hw_rst_n <= 0;
    repeat (5) @(posedge clk);
    hw_rst_n <= 1;
    repeat (10) @(posedge clk);
    st(CS_IDLE);
    chk("width", 32'h0, 32'(bus_width));
    $display("power and reset test done");
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    {rst_n, avs_read, avs_write, avs_address, avs_writedata, hw_rst_n} = {7'h0, 32'h0, 1'b1};
    failures = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1;
    t_reset;
    t_ident;
    t_sel;
    t_ops;
    t_sleep;
    t_psave_rst;
    end_sim();
  end
endmodule
